// ### verilog/tile_regs_pkg.sv
// constants for the tile status and control register group
`default_nettype none
package tile_regs_pkg;
  // ------------------------------------------------------------
  // register numbers
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam logic [7:0] REG_BOOT = 8'h03;
  localparam logic [7:0] REG_SEC = 8'h05;
  localparam logic [7:0] REG_OSC = 8'h06;
  localparam logic [7:0] REG_OSCV0 = 8'h07;
  localparam logic [7:0] REG_OSCV3 = 8'h0A;
  // ------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_WMASK = 32'h03FF_FF36;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SEC_WMASK = 32'h8000_5FB1;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [31:0] OSC_WMASK = 32'h0000_0003;
  localparam logic [31:0] OSC_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // tile control fields
  // ------------------------------------------------------------
  localparam int CTRL_DLY_LSB = 18;
  localparam int CTRL_DLY_W = 8;
  localparam int CTRL_DIV_LSB = 9;
  localparam int CTRL_DIV_W = 9;
  localparam int CTRL_ETH_EN = 8;
  localparam int CTRL_DYN = 5;
  localparam int CTRL_DIV_EN = 4;
  localparam int CTRL_UTMI = 2;
  localparam int CTRL_ULPI = 1;
  // ------------------------------------------------------------
  // boot status fields
  // ------------------------------------------------------------
  localparam int BOOT_PROC_LSB = 16;
  localparam int BOOT_OVR = 8;
  localparam int BOOT_CORE_OFF = 5;
  localparam int BOOT_NO_POLL = 4;
  localparam int BOOT_RAM = 3;
  localparam int BOOT_JTAG = 2;
  localparam int BOOT_PLL_W = 2;
  // ------------------------------------------------------------
  // security fields
  // ------------------------------------------------------------
  localparam int SEC_LOCK = 31;
  localparam int SEC_GDBG = 14;
  localparam int SEC_LOCK_ALL = 12;
  localparam int SEC_SECT_LSB = 8;
  localparam int SEC_SECT_W = 4;
  localparam int SEC_REDUND = 7;
  localparam int SEC_OTP_BOOT = 5;
  localparam int SEC_JCFG = 4;
  localparam int SEC_TAP = 0;
  // ------------------------------------------------------------
  // oscillators
  // ------------------------------------------------------------
  localparam int OSC_CORE = 1;
  localparam int OSC_PERIPH = 0;
  localparam int OSC_NUM = 4;
  localparam int OSC_CNT_W = 16;
  localparam int PIN_WARMUP = 3;
endpackage : tile_regs_pkg
`default_nettype wire

// ### verilog/osc_counter.sv
// ring oscillator sampler and counter of ring rises while run is high
`timescale 1ns/1ns
`default_nettype none
module osc_counter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ring,
  input wire logic run,
  output logic [W-1:0] count
);
  // ------------------------------------------------------------
  // three-stage sampler of the asynchronous ring
  // ------------------------------------------------------------
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic [W-1:0] cnt_q = '0; // power-up value, reset leaves it alone
  wire agree = (s2_q == s3_q);
  wire rise = agree && s2_q && !level_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= ring;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_q <= s2_q;
      end
    end
  end

  // ------------------------------------------------------------
  // counter keeps its value across reset
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (run && rise) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign count = cnt_q;

  property p_osc_hold;
    @(posedge clk) disable iff (!rst_n) !run |=> cnt_q == $past(cnt_q);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("stopped counter moved");

  property p_osc_step;
    @(posedge clk) disable iff (!rst_n) (run && rise) |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_osc_step: assert property (p_osc_step) else $error("counter missed a ring edge");
endmodule : osc_counter
`default_nettype wire

// ### verilog/tile_status_control_regs.sv
// processor-status register group of one tile
`timescale 1ns/1ns
`default_nettype none
module tile_status_control_regs #(
  parameter int LP_DIV = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ps_rd,
  input wire logic ps_wr,
  input wire logic [7:0] ps_addr,
  input wire logic [31:0] ps_wdata,
  output logic [31:0] ps_rdata,
  output logic ps_ack,
  output logic ps_err,
  input wire logic otp_sec_load,
  input wire logic [31:0] otp_sec_word,
  input wire logic all_threads_paused,
  input wire logic [7:0] proc_number,
  input wire logic boot_mode_override,
  input wire logic second_core_off,
  input wire logic otp_skip_poll,
  input wire logic boot_from_ram,
  input wire logic boot_from_jtag,
  input wire logic [1:0] boot_pll_pins,
  input wire logic [3:0] ring_osc,
  output logic rgmii_tx_clk,
  output logic rgmii_tx_launch,
  output logic rgmii_port_en,
  output logic core_clk_en,
  output logic utmi_sel,
  output logic ulpi_assist_en,
  output logic global_debug_off,
  output logic debug_tap_off,
  output logic jtag_cfg_off,
  output logic otp_boot_force,
  output logic otp_redundancy_en,
  output logic otp_lock_all,
  output logic [3:0] otp_sector_lock,
  output logic core_osc_en,
  output logic periph_osc_en
);
  localparam int LP_W = $clog2(LP_DIV + 1);
  localparam int DW = tile_regs_pkg::CTRL_DIV_W;
  localparam int YW = tile_regs_pkg::CTRL_DLY_W;
  localparam int CW = tile_regs_pkg::OSC_CNT_W;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] sec_q;
  logic [31:0] osc_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic err_q;
  logic [DW-1:0] txc_cnt_q;
  logic tx_clk_q;
  logic [YW-1:0] dly_cnt_q;
  logic dly_busy_q;
  logic launch_q;
  logic [LP_W-1:0] lp_cnt_q;
  logic clk_en_q;
  logic [1:0] p1_q;
  logic [1:0] p2_q;
  logic [1:0] p3_q;
  logic [1:0] pll_mode_q;
  logic [1:0] warm_q;
  logic pll_cap_q;
  logic [CW-1:0] osc_cnt [tile_regs_pkg::OSC_NUM];

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  wire hit_ctrl = (ps_addr == tile_regs_pkg::REG_CTRL);
  wire hit_boot = (ps_addr == tile_regs_pkg::REG_BOOT);
  wire hit_sec = (ps_addr == tile_regs_pkg::REG_SEC);
  wire hit_osc = (ps_addr == tile_regs_pkg::REG_OSC);
  wire hit_val = (ps_addr >= tile_regs_pkg::REG_OSCV0) && (ps_addr <= tile_regs_pkg::REG_OSCV3);
  wire mapped = hit_ctrl | hit_boot | hit_sec | hit_osc | hit_val;
  wire sec_locked = sec_q[tile_regs_pkg::SEC_LOCK];
  wire wr_ctrl = ps_wr && hit_ctrl;
  wire wr_osc = ps_wr && hit_osc;
  wire wr_sec = ps_wr && hit_sec && !sec_locked;
  wire wr_bad = ps_wr && (!mapped || hit_boot || hit_val || (hit_sec && sec_locked));
  wire rd_bad = ps_rd && !ps_wr && !mapped;
  wire [1:0] val_idx = 2'(ps_addr - tile_regs_pkg::REG_OSCV0);

  // ------------------------------------------------------------
  // register next values
  // ------------------------------------------------------------
  wire [31:0] ctrl_d = (ctrl_q & ~tile_regs_pkg::CTRL_WMASK)
                     | (ps_wdata & tile_regs_pkg::CTRL_WMASK);
  wire [31:0] osc_d = (osc_q & ~tile_regs_pkg::OSC_WMASK)
                    | (ps_wdata & tile_regs_pkg::OSC_WMASK);
  wire [31:0] sec_wd = (sec_q & ~tile_regs_pkg::SEC_WMASK)
                     | (ps_wdata & tile_regs_pkg::SEC_WMASK);
  wire [31:0] sec_ld = otp_sec_word & tile_regs_pkg::SEC_WMASK;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire [31:0] boot_word = {8'h00, proc_number, 7'h00, boot_mode_override, 2'h0,
                           second_core_off, otp_skip_poll, boot_from_ram,
                           boot_from_jtag, pll_mode_q};
  wire [31:0] val_word = {16'h0000, osc_cnt[val_idx]};
  wire [31:0] rd_word = hit_ctrl ? ctrl_q :
                        hit_boot ? boot_word :
                        hit_sec ? sec_q :
                        hit_osc ? osc_q :
                        hit_val ? val_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= tile_regs_pkg::CTRL_RESET;
      osc_q <= tile_regs_pkg::OSC_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_d;
      end
      if (wr_osc) begin
        osc_q <= osc_d;
      end
    end
  end

  // hardware load from OTP wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_q <= tile_regs_pkg::SEC_RESET;
    end else if (otp_sec_load) begin
      sec_q <= sec_ld;
    end else if (wr_sec) begin
      sec_q <= sec_wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= ps_rd | ps_wr;
      err_q <= wr_bad | rd_bad;
      if (ps_rd && !ps_wr) begin
        rdata_q <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------
  // boot PLL mode pins, captured once after reset release
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= 2'h0;
      p2_q <= 2'h0;
      p3_q <= 2'h0;
      warm_q <= 2'h0;
      pll_cap_q <= 1'b0;
      pll_mode_q <= 2'h0;
    end else begin
      p1_q <= boot_pll_pins;
      p2_q <= p1_q;
      p3_q <= p2_q;
      if (warm_q != 2'(tile_regs_pkg::PIN_WARMUP)) begin
        warm_q <= warm_q + 2'h1;
      end else if (!pll_cap_q && (p2_q == p3_q)) begin
        pll_cap_q <= 1'b1;
        pll_mode_q <= p2_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Ethernet transmit clock and data delay
  // ------------------------------------------------------------
  wire eth_en = ctrl_q[tile_regs_pkg::CTRL_ETH_EN];
  wire [DW-1:0] div_val = ctrl_q[tile_regs_pkg::CTRL_DIV_LSB +: DW];
  wire [YW-1:0] dly_val = ctrl_q[tile_regs_pkg::CTRL_DLY_LSB +: YW];
  wire txc_hit = (txc_cnt_q == div_val);
  wire txc_half = (txc_cnt_q == (div_val >> 1));
  wire [DW-1:0] txc_next = txc_hit ? '0 : txc_cnt_q + 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_cnt_q <= '0;
      tx_clk_q <= 1'b0;
    end else if (!eth_en) begin
      txc_cnt_q <= '0;
      tx_clk_q <= 1'b0;
    end else begin
      txc_cnt_q <= txc_next;
      if (txc_hit) begin
        tx_clk_q <= 1'b1;
      end else if (txc_half) begin
        tx_clk_q <= 1'b0;
      end
    end
  end

  // launch pulse follows each rising edge by the delay field in cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_q <= '0;
      dly_busy_q <= 1'b0;
      launch_q <= 1'b0;
    end else if (eth_en && txc_hit) begin
      dly_cnt_q <= dly_val;
      dly_busy_q <= (dly_val != '0);
      launch_q <= (dly_val == '0);
    end else if (dly_busy_q) begin
      dly_cnt_q <= dly_cnt_q - 1'b1;
      dly_busy_q <= (dly_cnt_q != YW'(1));
      launch_q <= (dly_cnt_q == YW'(1));
    end else begin
      launch_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // low-power core clock enable
  // ------------------------------------------------------------
  wire div_en = ctrl_q[tile_regs_pkg::CTRL_DIV_EN];
  wire dyn_mode = ctrl_q[tile_regs_pkg::CTRL_DYN];
  wire div_active = div_en && (!dyn_mode || all_threads_paused);
  wire lp_last = (lp_cnt_q == LP_W'(LP_DIV - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_cnt_q <= '0;
      clk_en_q <= 1'b1;
    end else if (div_active) begin
      lp_cnt_q <= lp_last ? '0 : lp_cnt_q + 1'b1;
      clk_en_q <= lp_last;
    end else begin
      lp_cnt_q <= '0;
      clk_en_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // ring oscillator counters: 0/1 core, 2/3 peripheral
  // ------------------------------------------------------------
  for (genvar i = 0; i < tile_regs_pkg::OSC_NUM; i++) begin : g_osc
    osc_counter #(.W(CW)) u_osc (
      .clk(clk),
      .rst_n(rst_n),
      .ring(ring_osc[i]),
      .run(i < 2 ? osc_q[tile_regs_pkg::OSC_CORE] : osc_q[tile_regs_pkg::OSC_PERIPH]),
      .count(osc_cnt[i])
    );
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign ps_rdata = rdata_q;
  assign ps_ack = ack_q;
  assign ps_err = err_q;
  assign rgmii_tx_clk = tx_clk_q;
  assign rgmii_tx_launch = launch_q;
  assign rgmii_port_en = ctrl_q[tile_regs_pkg::CTRL_ETH_EN];
  assign core_clk_en = clk_en_q;
  assign utmi_sel = ctrl_q[tile_regs_pkg::CTRL_UTMI];
  assign ulpi_assist_en = ctrl_q[tile_regs_pkg::CTRL_ULPI];
  assign global_debug_off = sec_q[tile_regs_pkg::SEC_GDBG];
  assign debug_tap_off = sec_q[tile_regs_pkg::SEC_TAP];
  assign jtag_cfg_off = sec_q[tile_regs_pkg::SEC_JCFG];
  assign otp_boot_force = sec_q[tile_regs_pkg::SEC_OTP_BOOT];
  assign otp_redundancy_en = sec_q[tile_regs_pkg::SEC_REDUND];
  assign otp_lock_all = sec_q[tile_regs_pkg::SEC_LOCK_ALL];
  assign otp_sector_lock = sec_q[tile_regs_pkg::SEC_SECT_LSB +: tile_regs_pkg::SEC_SECT_W];
  assign core_osc_en = osc_q[tile_regs_pkg::OSC_CORE];
  assign periph_osc_en = osc_q[tile_regs_pkg::OSC_PERIPH];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ctrl_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_ctrl |=> ctrl_q == ($past(ps_wdata) & tile_regs_pkg::CTRL_WMASK);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_txc_rise;
    @(posedge clk) disable iff (!rst_n) (eth_en && txc_hit) |=> tx_clk_q && txc_cnt_q == '0;
  endproperty
  a_txc_rise: assert property (p_txc_rise) else $error("tx clock did not rise");

  property p_txc_fall;
    @(posedge clk) disable iff (!rst_n) (eth_en && txc_half && !txc_hit) |=> !tx_clk_q;
  endproperty
  a_txc_fall: assert property (p_txc_fall) else $error("tx clock did not fall");

  property p_dyn_run;
    @(posedge clk) disable iff (!rst_n)
      (div_en && dyn_mode && !all_threads_paused) |=> clk_en_q;
  endproperty
  a_dyn_run: assert property (p_dyn_run) else $error("divided while threads run");

  property p_static_div;
    @(posedge clk) disable iff (!rst_n)
      (LP_DIV > 1 && div_en && !dyn_mode && clk_en_q && lp_cnt_q == '0) |=> !clk_en_q;
  endproperty
  a_static_div: assert property (p_static_div) else $error("static divider idle");

  property p_sec_lock;
    @(posedge clk) disable iff (!rst_n)
      (ps_wr && hit_sec && sec_locked && !otp_sec_load) |=> sec_q == $past(sec_q) && err_q;
  endproperty
  a_sec_lock: assert property (p_sec_lock) else $error("locked security written");

  property p_sec_load;
    @(posedge clk) disable iff (!rst_n) otp_sec_load |=> sec_q == $past(sec_ld);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security copy not loaded");

  property p_boot_ro;
    @(posedge clk) disable iff (!rst_n) (ps_wr && hit_boot) |=> err_q && ack_q;
  endproperty
  a_boot_ro: assert property (p_boot_ro) else $error("boot status write accepted");

  property p_boot_pll;
    @(posedge clk) disable iff (!rst_n)
      (ps_rd && !ps_wr && hit_boot) |=> rdata_q[1:0] == $past(pll_mode_q);
  endproperty
  a_boot_pll: assert property (p_boot_pll) else $error("pll mode misreported");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rst_n)
      (ps_rd && !ps_wr && hit_val) |=> rdata_q[31:CW] == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
endmodule : tile_status_control_regs
`default_nettype wire

// ### sim/tb_tile_status_control_regs.sv
// self-checking bench for the tile status and control register group
`timescale 1ns/1ns
`default_nettype none
module tb_tile_status_control_regs;
  localparam int LPD = 2;
  logic clk, rst_n, ps_rd, ps_wr, otp_sec_load, all_threads_paused;
  logic boot_mode_override, second_core_off, otp_skip_poll, boot_from_ram, boot_from_jtag;
  logic [7:0] ps_addr, proc_number;
  logic [31:0] ps_wdata, otp_sec_word, ps_rdata, v;
  logic [1:0] boot_pll_pins;
  logic [3:0] ring_osc, otp_sector_lock;
  logic ps_ack, ps_err, rgmii_tx_clk, rgmii_tx_launch, rgmii_port_en, core_clk_en, utmi_sel;
  logic ulpi_assist_en, global_debug_off, debug_tap_off, jtag_cfg_off, otp_boot_force;
  logic otp_redundancy_en, otp_lock_all, core_osc_en, periph_osc_en, prev_c;
  logic [7:0] rise_h;
  int failures, n_compared;
  integer s_hi, s_up, s_lch, s_bad, s_en;
  logic [31:0] cnt_q [4];

  tile_status_control_regs #(.LP_DIV(LPD)) i_dut (
    .clk(clk), .rst_n(rst_n), .ps_rd(ps_rd), .ps_wr(ps_wr), .ps_addr(ps_addr),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_ack(ps_ack), .ps_err(ps_err),
    .otp_sec_load(otp_sec_load), .otp_sec_word(otp_sec_word),
    .all_threads_paused(all_threads_paused), .proc_number(proc_number),
    .boot_mode_override(boot_mode_override), .second_core_off(second_core_off),
    .otp_skip_poll(otp_skip_poll), .boot_from_ram(boot_from_ram),
    .boot_from_jtag(boot_from_jtag), .boot_pll_pins(boot_pll_pins), .ring_osc(ring_osc),
    .rgmii_tx_clk(rgmii_tx_clk), .rgmii_tx_launch(rgmii_tx_launch),
    .rgmii_port_en(rgmii_port_en), .core_clk_en(core_clk_en), .utmi_sel(utmi_sel),
    .ulpi_assist_en(ulpi_assist_en), .global_debug_off(global_debug_off),
    .debug_tap_off(debug_tap_off), .jtag_cfg_off(jtag_cfg_off),
    .otp_boot_force(otp_boot_force), .otp_redundancy_en(otp_redundancy_en),
    .otp_lock_all(otp_lock_all), .otp_sector_lock(otp_sector_lock),
    .core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic e, output logic [31:0] rd);
    @(posedge clk);
    #1;
    ps_wr = wr;
    ps_rd = !wr;
    ps_addr = a;
    ps_wdata = d;
    @(posedge clk);
    #1;
    ps_wr = 1'b0;
    ps_rd = 1'b0;
    cmp("ps_ack", 1'b1, ps_ack);
    cmp("ps_err", e, ps_err);
    rd = ps_rdata;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d, e, v);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0, v);
    cmp(what, exp, v);
  endtask : rdchk

  // counts clock levels, rises, launches and enable pulses over n cycles
  task automatic sample(input int n, input int d);
    {s_hi, s_up, s_lch, s_bad, s_en} = '0;
    repeat (n) begin
      @(posedge clk);
      #1;
      rise_h = {rise_h[6:0], rgmii_tx_clk & ~prev_c};
      prev_c = rgmii_tx_clk;
      s_hi += rgmii_tx_clk;
      s_up += rise_h[0];
      s_lch += rgmii_tx_launch;
      s_bad += rgmii_tx_launch & ~rise_h[d];
      s_en += core_clk_en;
    end
  endtask : sample

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk("ctrl reset", tile_regs_pkg::REG_CTRL, 32'h0000_0000);
    rdchk("osc reset", tile_regs_pkg::REG_OSC, 32'h0000_0000);
    cmp("core_clk_en reset", 1'b1, core_clk_en);
    wr(tile_regs_pkg::REG_CTRL, 32'hFFFF_FFFF, 1'b0);
    rdchk("ctrl mask", tile_regs_pkg::REG_CTRL, 32'h03FF_FF36);
    cmp("ctrl bits", 3'h7, {rgmii_port_en, utmi_sel, ulpi_assist_en});
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0004, 1'b0);
    cmp("utmi only", 3'h2, {rgmii_port_en, utmi_sel, ulpi_assist_en});
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0002, 1'b0);
    cmp("ulpi only", 3'h1, {rgmii_port_en, utmi_sel, ulpi_assist_en});
    wr(8'h04, 32'h0000_0001, 1'b1);
    acc(1'b0, 8'hFF, 32'h0, 1'b1, v);
    $display("test registers done");
  endtask : t_regs

  task automatic t_boot;
    logic [31:0] e;
    for (int k = 0; k < 2; k++) begin
      proc_number = k ? 8'hA5 : 8'h3C;
      {boot_mode_override, second_core_off, otp_skip_poll, boot_from_ram, boot_from_jtag} =
        k ? 5'h15 : 5'h0A;
      e = {8'h00, proc_number, 7'h00, boot_mode_override, 2'h0, second_core_off,
           otp_skip_poll, boot_from_ram, boot_from_jtag, 2'h2};
      rdchk("boot status", tile_regs_pkg::REG_BOOT, e);
    end
    wr(tile_regs_pkg::REG_BOOT, 32'hFFFF_FFFF, 1'b1);
    rdchk("boot after write", tile_regs_pkg::REG_BOOT, e);
    $display("test boot status done");
  endtask : t_boot

  task automatic otp_load(input logic [31:0] w);
    @(posedge clk);
    #1;
    otp_sec_word = w;
    otp_sec_load = 1'b1;
    @(posedge clk);
    #1;
    otp_sec_load = 1'b0;
  endtask : otp_load

  task automatic t_sec;
    rdchk("sec reset", tile_regs_pkg::REG_SEC, 32'h0000_0000);
    otp_load(32'h7FFF_FFFF);
    rdchk("sec otp copy", tile_regs_pkg::REG_SEC, 32'h0000_5FB1);
    cmp("sec outs all", 10'h3FF, {global_debug_off, debug_tap_off, jtag_cfg_off,
        otp_boot_force, otp_redundancy_en, otp_lock_all, otp_sector_lock});
    wr(tile_regs_pkg::REG_SEC, 32'h0000_4000, 1'b0);
    cmp("sec outs gdbg", 10'h200, {global_debug_off, debug_tap_off, jtag_cfg_off,
        otp_boot_force, otp_redundancy_en, otp_lock_all, otp_sector_lock});
    wr(tile_regs_pkg::REG_SEC, 32'h8000_0011, 1'b0);
    cmp("sec outs tap", 10'h180, {global_debug_off, debug_tap_off, jtag_cfg_off,
        otp_boot_force, otp_redundancy_en, otp_lock_all, otp_sector_lock});
    wr(tile_regs_pkg::REG_SEC, 32'h0000_0FA0, 1'b1);
    rdchk("sec locked", tile_regs_pkg::REG_SEC, 32'h8000_0011);
    otp_load(32'h0000_0000);
    rdchk("sec reload", tile_regs_pkg::REG_SEC, 32'h0000_0000);
    $display("test security done");
  endtask : t_sec

  task automatic t_eth;
    for (int d = 0; d < 3; d += 2) begin
      wr(tile_regs_pkg::REG_CTRL, 32'h0000_0900 | (d << 18), 1'b0);
      sample(10, d);
      sample(20, d);
      cmp("tx clk high", 12, s_hi);
      cmp("tx clk rises", 4, s_up);
      cmp("launch count", 4, s_lch);
      cmp("launch late", 0, s_bad);
    end
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0000, 1'b0);
    sample(10, 0);
    cmp("tx clk idle", 0, s_hi);
    $display("test ethernet clock done");
  endtask : t_eth

  task automatic t_div;
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0010, 1'b0);
    sample(4, 0);
    sample(8, 0);
    cmp("static divide", 8 / LPD, s_en);
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0030, 1'b0);
    sample(4, 0);
    sample(8, 0);
    cmp("dynamic running", 8, s_en);
    all_threads_paused = 1'b1;
    sample(4, 0);
    sample(8, 0);
    cmp("dynamic paused", 8 / LPD, s_en);
    wr(tile_regs_pkg::REG_CTRL, 32'h0000_0000, 1'b0);
    $display("test clock divider done");
  endtask : t_div

  task automatic t_osc;
    wr(tile_regs_pkg::REG_OSC, 32'hFFFF_FFFF, 1'b0);
    rdchk("osc ctrl", tile_regs_pkg::REG_OSC, 32'h0000_0003);
    cmp("osc enables", 2'h3, {core_osc_en, periph_osc_en});
    // ring edges four cycles apart so the sampler sees every level
    repeat (20) begin
      repeat (4) @(posedge clk);
      #1;
      ring_osc = ~ring_osc;
    end
    wr(tile_regs_pkg::REG_OSC, 32'h0000_0001, 1'b0);
    cmp("osc periph only", 2'h1, {core_osc_en, periph_osc_en});
    repeat (8) begin
      repeat (4) @(posedge clk);
      #1;
      ring_osc = ~ring_osc;
    end
    wr(tile_regs_pkg::REG_OSC, 32'h0000_0000, 1'b0);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 8'(tile_regs_pkg::REG_OSCV0 + i), 32'h0, 1'b0, cnt_q[i]);
      cmp("osc count top", 16'h0000, cnt_q[i][31:16]);
      cmp("osc count", i < 2 ? 32'h0000_000A : 32'h0000_000E, cnt_q[i]);
    end
    wr(tile_regs_pkg::REG_OSCV3, 32'h0000_FFFF, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk("osc count kept", 8'(tile_regs_pkg::REG_OSCV0 + i), cnt_q[i]);
    end
    $display("test oscillators done");
  endtask : t_osc

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    {ps_rd, ps_wr, otp_sec_load, all_threads_paused, boot_mode_override} = '0;
    {second_core_off, otp_skip_poll, boot_from_ram, boot_from_jtag, prev_c} = '0;
    {ps_addr, ps_wdata, otp_sec_word, proc_number, ring_osc, rise_h} = '0;
    boot_pll_pins = 2'h2;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_boot();
    t_sec();
    t_eth();
    t_div();
    t_osc();
    tally_and_finish();
  end
endmodule : tb_tile_status_control_regs
`default_nettype wire
